// ===== kbd_link_pkg.sv
// Constants shared by the keyboard link controller files.
package kbd_link_pkg;
   localparam int           ADDR_W          = 3;
   localparam int           DATA_W          = 8;
   localparam logic [2:0]   OFF_CTRL_HIGH   = 3'h0;
   localparam logic [2:0]   OFF_CTRL_LOW    = 3'h1;
   localparam logic [2:0]   OFF_RX_BUFFER   = 3'h2;
   localparam logic [2:0]   OFF_TX_DATA     = 3'h3;
   localparam logic [2:0]   OFF_MODULE_STOP = 3'h4;
   localparam logic [2:0]   OFF_IRQ_STATUS  = 3'h5;
   localparam logic [2:0]   OFF_IRQ_MASK    = 3'h6;
   // Control high register fields.
   localparam int           POS_FLAG_SELECT = 7;
   localparam int           POS_IO_ENABLE   = 6;
   localparam int           POS_RX_LOAD_EN  = 5;
   localparam int           POS_TX_START    = 4;
   // Control low register fields.
   localparam int           POS_BUF_FULL    = 7;
   localparam int           POS_CLK_IN      = 6;
   localparam int           POS_DATA_IN     = 5;
   localparam int           POS_CLK_OUT     = 4;
   localparam int           POS_DATA_OUT    = 3;
   localparam int           POS_TX_BUSY     = 2;
   // Interrupt status bits.
   localparam int           IRQ_BUF_FULL    = 0;
   localparam int           IRQ_TX_DONE     = 1;
   localparam int           IRQ_W           = 2;
   // Reset values, then the receive counter codes and the last transmit count.
   localparam logic         RST_FLAG_SELECT = 1'b1;
   localparam logic         RST_MODULE_STOP = 1'b1;
   localparam logic [3:0]   RX_IDLE         = 4'h0;
   localparam logic [3:0]   RX_START        = 4'h1;
   localparam logic [3:0]   RX_PARITY       = 4'ha;
   localparam logic [3:0]   RX_STOP         = 4'hb;
   localparam logic [3:0]   TX_LAST_BIT     = 4'ha;
endpackage

// ===== kbd_line_sync.sv
// Two-flop synchroniser with the I/O enable gate and a falling edge detector.
`timescale 1ns/100ps
module kbd_line_sync (
   input  wire logic ref_clk,
   input  wire logic nrst,
   input  wire logic pin_in,
   input  wire logic io_enable,
   output logic      level,
   output logic      fall
);
   logic meta_q, sync_q, gated_q;
   logic gated_d;

   // Disabled input reads as 1, so enabling over a low pin yields a fall.
   always_comb begin
      gated_d = io_enable ? sync_q : 1'b1;   // see [R7] [R8]
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         meta_q  <= 1'b1;
         sync_q  <= 1'b1;
         gated_q <= 1'b1;
      end else begin
         meta_q  <= pin_in;
         sync_q  <= meta_q;
         gated_q <= gated_d;
      end
   end

   assign level = gated_q;
   assign fall  = gated_q & ~gated_d;
endmodule

// ===== kbd_link_ctrl.sv
// Keyboard two-wire link controller: receive, transmit, abort and registers.
//
// Overview of operation
// [R1] Transmit start, 8 data LSB first, parity, stop.
// [R2] Keyboard clocks transmit; device drives data.
// [R3] Transmit bit stable while link clock high.
// [R4] Abort reception by holding clock low.
// [R5] Keyboard stops sending on seeing low clock.
// [R6] Flag select zero: flag marks clock falls.
// [R7] Disabled I/O forces internal inputs to one.
// [R8] Enabling over low clock gives falling edge.
// [R9] That edge sets flag when select, load off.
// [R10] Reset leaves block halted in module stop.
// [R11] Registers act only after module stop cleared.
// [R12] Receive samples data while clock low.
// [R13] Receive counter steps per fall, clears after stop.
// [R14] Receive buffer valid only while flag set.
// [R15] Parity makes nine bits odd ones.
`timescale 1ns/100ps
module kbd_link_ctrl
   import kbd_link_pkg::*;
(
   input  wire logic                         ref_clk,
   input  wire logic                         nrst,
   input  wire logic [kbd_link_pkg::ADDR_W-1:0] addr,
   input  wire logic [kbd_link_pkg::DATA_W-1:0] wdata,
   input  wire logic                         wr_en,
   input  wire logic                         rd_en,
   output logic      [kbd_link_pkg::DATA_W-1:0] rdata,
   input  wire logic                         link_clock_line_in,
   output logic                              link_clock_line_out,
   output logic                              link_clock_line_oe,
   input  wire logic                         link_data_line_in,
   output logic                              link_data_line_out,
   output logic                              link_data_line_oe,
   output logic                              irq
);
   import kbd_link_pkg::*;

   typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;

   logic       clk_lvl, clk_fall, dat_lvl;
   logic       mstop_q, mstop_d;
   logic       flag_select_q, flag_select_d;
   logic       io_enable_q, io_enable_d;
   logic       receive_load_enable_q, receive_load_enable_d;
   logic       clock_output_control_q, clock_output_control_d;
   logic       data_output_control_q, data_output_control_d;
   logic       buffer_full_flag_q, buffer_full_flag_d;
   logic [7:0] receive_data_buffer_q, receive_data_buffer_d;
   logic [7:0] rx_shift_q, rx_shift_d;
   logic [3:0] rx_count_q, rx_count_d;
   logic [7:0] tx_data_q, tx_data_d;
   logic [9:0] tx_shift_q, tx_shift_d;
   logic [3:0] tx_count_q, tx_count_d;
   tx_state_t  tx_state_q, tx_state_d;
   logic [IRQ_W-1:0] irq_stat_q, irq_stat_d, irq_mask_q, irq_mask_d, irq_evt;
   logic [7:0] rdata_d;
   logic       irq_d, clk_oe_d, dat_oe_d;
   logic       wr_ok;

   kbd_line_sync u_clk_sync (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .pin_in    (link_clock_line_in),
      .io_enable (io_enable_q),
      .level     (clk_lvl),
      .fall      (clk_fall)
   );

   kbd_line_sync u_dat_sync (
      .ref_clk   (ref_clk),
      .nrst      (nrst),
      .pin_in    (link_data_line_in),
      .io_enable (io_enable_q),
      .level     (dat_lvl),
      .fall      ()
   );

   function automatic logic hit(input logic [ADDR_W-1:0] a, input logic [ADDR_W-1:0] off);
      hit = (a == off);
   endfunction

   // Module stop is always reachable; other writes are ignored while it is set.
   assign wr_ok = wr_en & ~mstop_q;   // see [R11]

   always_comb begin
      mstop_d                = mstop_q;
      flag_select_d          = flag_select_q;
      io_enable_d            = io_enable_q;
      receive_load_enable_d  = receive_load_enable_q;
      clock_output_control_d = clock_output_control_q;
      data_output_control_d  = data_output_control_q;
      buffer_full_flag_d     = buffer_full_flag_q;
      receive_data_buffer_d  = receive_data_buffer_q;
      rx_shift_d             = rx_shift_q;
      rx_count_d             = rx_count_q;
      tx_data_d              = tx_data_q;
      tx_shift_d             = tx_shift_q;
      tx_count_d             = tx_count_q;
      tx_state_d             = tx_state_q;
      irq_evt                = '0;
      if (wr_en && hit(addr, OFF_MODULE_STOP)) begin
         mstop_d = wdata[0];   // see [R10]
      end
      if (wr_ok) begin
         if (hit(addr, OFF_CTRL_HIGH)) begin
            flag_select_d         = wdata[POS_FLAG_SELECT];
            io_enable_d           = wdata[POS_IO_ENABLE];
            receive_load_enable_d = wdata[POS_RX_LOAD_EN];
         end else if (hit(addr, OFF_CTRL_LOW)) begin
            clock_output_control_d = wdata[POS_CLK_OUT];   // see [R4]
            data_output_control_d  = wdata[POS_DATA_OUT];
            if (!wdata[POS_BUF_FULL]) begin
               buffer_full_flag_d = 1'b0;
            end
         end else if (hit(addr, OFF_TX_DATA)) begin
            tx_data_d = wdata;
         end
      end
      // Receive path: the counter walks start, data and parity on falls; the stop fall clears it.
      if (!receive_load_enable_q || !io_enable_q) begin
         rx_count_d = RX_IDLE;
      end else if (clk_fall && !buffer_full_flag_q && tx_state_q == TX_IDLE) begin
         // The stop bit falls while the counter still shows the parity code.
         if (rx_count_q == RX_PARITY) begin
            rx_count_d            = RX_IDLE;   // see [R13]
            buffer_full_flag_d    = 1'b1;
            receive_data_buffer_d = rx_shift_q;
            irq_evt[IRQ_BUF_FULL] = 1'b1;
         end else begin
            rx_count_d = rx_count_q + 4'h1;   // see [R13]
            // Only the codes that name data bits shift; the parity bit is not kept.
            if (rx_count_d > RX_START && rx_count_d < RX_PARITY) begin
               rx_shift_d = {dat_lvl, rx_shift_q[7:1]};   // see [R12]
            end
         end
      end
      // Clock-fall interrupt mode reuses the flag; the enable edge counts too.
      if (clk_fall && !flag_select_q && !receive_load_enable_q) begin
         buffer_full_flag_d    = 1'b1;   // see [R6] [R9]
         irq_evt[IRQ_BUF_FULL] = 1'b1;
      end
      if (!io_enable_q) begin
         receive_data_buffer_d = 8'h00;
      end
      // Transmit: the keyboard clocks; a new bit goes out on each fall until the fall at the stop bit ends the frame.
      case (tx_state_q)
         TX_IDLE: begin
            if (wr_ok && hit(addr, OFF_CTRL_HIGH) && wdata[POS_TX_START]) begin
               tx_shift_d = {~^tx_data_d, tx_data_d, 1'b0};   // see [R1] [R15]
               tx_count_d = 4'h0;
               tx_state_d = TX_SHIFT;
            end
         end
         TX_SHIFT: begin
            if (clk_fall) begin
               // Bit changes only after a fall, so it holds across the high phase.
               if (tx_count_q == TX_LAST_BIT) begin
                  tx_state_d            = TX_IDLE;   // see [R3]
                  irq_evt[IRQ_TX_DONE]  = 1'b1;
               end else begin
                  tx_shift_d = {1'b1, tx_shift_q[9:1]};
                  tx_count_d = tx_count_q + 4'h1;
               end
            end
         end
         default: tx_state_d = TX_IDLE;
      endcase
      if (mstop_q) begin
         tx_state_d = TX_IDLE;
         rx_count_d = RX_IDLE;
      end
   end

   // Set wins over the write-one clear.
   always_comb begin
      irq_mask_d = irq_mask_q;
      irq_stat_d = irq_stat_q;
      if (wr_ok && hit(addr, OFF_IRQ_MASK)) begin
         irq_mask_d = wdata[IRQ_W-1:0];
      end
      if (wr_ok && hit(addr, OFF_IRQ_STATUS)) begin
         irq_stat_d = irq_stat_q & ~wdata[IRQ_W-1:0];
      end
      irq_stat_d = irq_stat_d | irq_evt;
      irq_d      = |(irq_stat_d & irq_mask_d);
   end

   always_comb begin
      rdata_d = 8'h00;
      if (rd_en && !mstop_q) begin
         if (hit(addr, OFF_CTRL_HIGH)) begin
            rdata_d = {flag_select_q, io_enable_q, receive_load_enable_q, 5'h00};
         end else if (hit(addr, OFF_CTRL_LOW)) begin
            rdata_d = {buffer_full_flag_q, clk_lvl, dat_lvl, clock_output_control_q,
                       data_output_control_q, tx_state_q == TX_SHIFT, 2'h0};
         end else if (hit(addr, OFF_RX_BUFFER)) begin
            // Software should only trust this while the flag is set.
            rdata_d = receive_data_buffer_q;   // see [R14]
         end else if (hit(addr, OFF_TX_DATA)) begin
            rdata_d = tx_data_q;
         end else if (hit(addr, OFF_IRQ_STATUS)) begin
            rdata_d = {6'h00, irq_stat_q};
         end else if (hit(addr, OFF_IRQ_MASK)) begin
            rdata_d = {6'h00, irq_mask_q};
         end else if (hit(addr, OFF_MODULE_STOP)) begin
            rdata_d = {7'h00, mstop_q};
         end
      end else if (rd_en && hit(addr, OFF_MODULE_STOP)) begin
         rdata_d = {7'h00, mstop_q};
      end
      // Open-drain pins: drive only a low; the keyboard owns the clock in frames.
      clk_oe_d = io_enable_d & ~clock_output_control_d;   // see [R2] [R4] [R5]
      dat_oe_d = io_enable_d & ((tx_state_d == TX_SHIFT) ? ~tx_shift_d[0]
                                                         : ~data_output_control_d);
   end

   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         mstop_q                <= RST_MODULE_STOP;
         flag_select_q          <= RST_FLAG_SELECT;
         io_enable_q            <= 1'b0;
         receive_load_enable_q  <= 1'b0;
         clock_output_control_q <= 1'b1;
         data_output_control_q  <= 1'b1;
         buffer_full_flag_q     <= 1'b0;
         receive_data_buffer_q  <= 8'h00;
         rx_shift_q             <= 8'h00;
         rx_count_q             <= RX_IDLE;
         tx_data_q              <= 8'h00;
         tx_shift_q             <= 10'h3ff;
         tx_count_q             <= 4'h0;
         tx_state_q             <= TX_IDLE;
         irq_stat_q             <= '0;
         irq_mask_q             <= '0;
         irq                    <= 1'b0;
         rdata                  <= 8'h00;
         link_clock_line_oe     <= 1'b0;
         link_data_line_oe      <= 1'b0;
      end else begin
         mstop_q                <= mstop_d;
         flag_select_q          <= flag_select_d;
         io_enable_q            <= io_enable_d;
         receive_load_enable_q  <= receive_load_enable_d;
         clock_output_control_q <= clock_output_control_d;
         data_output_control_q  <= data_output_control_d;
         buffer_full_flag_q     <= buffer_full_flag_d;
         receive_data_buffer_q  <= receive_data_buffer_d;
         rx_shift_q             <= rx_shift_d;
         rx_count_q             <= rx_count_d;
         tx_data_q              <= tx_data_d;
         tx_shift_q             <= tx_shift_d;
         tx_count_q             <= tx_count_d;
         tx_state_q             <= tx_state_d;
         irq_stat_q             <= irq_stat_d;
         irq_mask_q             <= irq_mask_d;
         irq                    <= irq_d;
         rdata                  <= rdata_d;
         link_clock_line_oe     <= clk_oe_d;
         link_data_line_oe      <= dat_oe_d;
      end
   end

   // Pins are open drain, so the driven level is always low.
   always_ff @(posedge ref_clk) begin
      link_clock_line_out <= 1'b0;
      link_data_line_out  <= 1'b0;
   end

   sequence rx_frame_end_s;
      clk_fall && rx_count_q == RX_PARITY && !buffer_full_flag_q && tx_state_q == TX_IDLE
         && receive_load_enable_q && io_enable_q && !mstop_q;
   endsequence

   sequence rx_bit_step_s;
      clk_fall && rx_count_q != RX_PARITY && !buffer_full_flag_q && tx_state_q == TX_IDLE
         && receive_load_enable_q && io_enable_q && !mstop_q;
   endsequence

   mstop_reset_a: assert property (@(posedge ref_clk) $rose(nrst) |-> mstop_q) // see [R10]
      else $error("Module stop not set after reset.");
   stop_blocks_wr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R11]
      (mstop_q && wr_en && hit(addr, OFF_TX_DATA)) |=> $stable(tx_data_q))
      else $error("Write took effect during module stop.");
   io_gate_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R7]
      !io_enable_q |=> (clk_lvl && dat_lvl) || io_enable_q)
      else $error("Internal lines not forced high while disabled.");
   rx_stop_clr_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R13]
      rx_frame_end_s |=> rx_count_q == RX_IDLE && buffer_full_flag_q)
      else $error("Counter not cleared after stop bit.");
   rx_count_step_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R13]
      rx_bit_step_s |=> rx_count_q == $past(rx_count_q) + 4'h1)
      else $error("Receive counter did not advance on a clock fall.");
   fall_flag_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R6] [R9]
      (clk_fall && !flag_select_q && !receive_load_enable_q) |=> buffer_full_flag_q)
      else $error("Clock fall did not set flag.");
   tx_hold_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R3]
      (tx_state_q == TX_SHIFT && !clk_fall) |=> $stable(tx_shift_q[0]))
      else $error("Transmit bit changed without a clock fall.");
   tx_start_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R1] [R15]
      $rose(tx_state_q == TX_SHIFT) |-> tx_shift_q[0] == 1'b0 && ^tx_shift_q[9:1])
      else $error("Transmit frame start or parity wrong.");
   abort_drive_a: assert property (@(posedge ref_clk) disable iff (!nrst) // see [R4]
      (io_enable_q && !clock_output_control_q) |-> link_clock_line_oe)
      else $error("Clock line not held low for abort.");
   irq_level_a: assert property (@(posedge ref_clk) disable iff (!nrst)
      (|(irq_stat_q & irq_mask_q)) |-> irq)
      else $error("Interrupt output low with pending bit.");
endmodule

// ===== kbd_model.sv
// Behavioural keyboard that clocks the two-wire link from the far side.
`timescale 1ns/100ps
module kbd_model (
   input  wire logic clk_line,
   input  wire logic data_line,
   output logic      clk_low,
   output logic      data_low
);
   initial begin
      clk_low  = 1'b0;
      data_low = 1'b0;
   end
   // Each task first steps 5 ns past the system clock edge so the lines never move on it.
   task automatic hold(input logic c, input logic d);
      #5;
      clk_low  = c;
      data_low = d;
   endtask
   // Sends one frame; a low clock seen in the keyboard's own high phase ends it.
   task automatic send(input logic [7:0] b, output logic aborted);
      logic [10:0] f;
      #5;
      f = {1'b1, ~^b, b, 1'b0};
      aborted = 1'b0;
      for (int i = 0; i < 11 && !aborted; i++) begin
         data_low = ~f[i];
         #200;
         if (clk_line === 1'b0) begin
            aborted = 1'b1;
         end else begin
            clk_low = 1'b1;
            #200;
            clk_low = 1'b0;
         end
      end
      data_low = 1'b0;
   endtask
   // Clocks a frame out of the device, sampling in each high phase.
   task automatic recv(output logic [10:0] f);
      #5;
      for (int i = 0; i < 11; i++) begin
         #200;
         f[i]    = data_line;
         clk_low = 1'b1;
         #200;
         clk_low = 1'b0;
      end
   endtask
   task automatic pulse();
      #5;
      clk_low = 1'b1;
      #200;
      clk_low = 1'b0;
      #200;
   endtask
endmodule

// ===== keyboard_two_wire_buffer_tb.sv
// Self-checking bench for the keyboard link controller.
`timescale 1ns/100ps
module keyboard_two_wire_buffer_tb;
   import kbd_link_pkg::*;
   logic              ref_clk;
   logic              nrst;
   logic [ADDR_W-1:0] addr;
   logic [DATA_W-1:0] wdata;
   logic              wr_en;
   logic              rd_en;
   logic [DATA_W-1:0] rdata;
   logic              clk_out;
   logic              clk_oe;
   logic              data_out;
   logic              data_oe;
   logic              irq;
   wire               kb_clk_low;
   wire               kb_data_low;
   wire               clk_w;
   wire               data_w;
   logic [7:0]        exp_q[$];
   logic              rd_seen;
   logic [7:0]        b1;
   logic [7:0]        txb;
   logic [10:0]       frame;
   logic              ab;
   integer            seed;
   integer            bad_count;
   integer            comparisons;
   // Open-drain wires with pull-ups: any party enabling pulls the line low.
   assign clk_w  = (clk_oe ? clk_out : 1'b1) & ~kb_clk_low;
   assign data_w = (data_oe ? data_out : 1'b1) & ~kb_data_low;
   kbd_link_ctrl kbd_link_ctrl_i (
      .ref_clk(ref_clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_en(wr_en),
      .rd_en(rd_en), .rdata(rdata), .link_clock_line_in(clk_w),
      .link_clock_line_out(clk_out), .link_clock_line_oe(clk_oe),
      .link_data_line_in(data_w), .link_data_line_out(data_out),
      .link_data_line_oe(data_oe), .irq(irq)
   );
   kbd_model kbd_model_i (
      .clk_line(clk_w), .data_line(data_w), .clk_low(kb_clk_low), .data_low(kb_data_low)
   );
   initial begin
      ref_clk = 1'b0;
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic chk(input logic [10:0] seen, input logic [10:0] exp);
      comparisons++;
      if (seen !== exp) begin
         bad_count++;
         $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
      end
   endtask
   task automatic tally_and_finish();
      $display("comparisons=%0d mismatches=%0d", comparisons, bad_count);
      if (bad_count == 0 && comparisons > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask
   // Strobes stay up between back-to-back calls and drop in cyc, once per time step.
   task automatic wr(input logic [2:0] a, input logic [7:0] d);
      addr  <= a;
      wdata <= d;
      rd_en <= 1'b0;
      wr_en <= 1'b1;
      @(posedge ref_clk);
   endtask
   task automatic rd(input logic [2:0] a, input logic [7:0] e);
      addr  <= a;
      wr_en <= 1'b0;
      rd_en <= 1'b1;
      exp_q.push_back(e);
      @(posedge ref_clk);
   endtask
   task automatic cyc(input int n);
      wr_en <= 1'b0;
      rd_en <= 1'b0;
      repeat (n) @(posedge ref_clk);
   endtask
   // Read data stand in the cycle after the strobe; compare the oldest note then.
   always @(posedge ref_clk) begin
      if (rd_seen === 1'b1) begin
         chk(rdata, exp_q.pop_front());
      end
      rd_seen <= rd_en;
   end
   initial begin
      #400000;
      bad_count++;
      tally_and_finish();
   end
   initial begin
      nrst        = 1'b0;
      addr        = '0;
      wdata       = '0;
      rd_seen     = 1'b0;
      seed        = 25;
      bad_count   = 0;
      comparisons = 0;
      cyc(5);
      nrst <= 1'b1;
      cyc(1);
      rd(OFF_MODULE_STOP, 8'h01);
      rd(OFF_CTRL_HIGH, 8'h00);
      wr(OFF_CTRL_HIGH, 8'h60);
      wr(OFF_TX_DATA, 8'ha5);
      wr(OFF_MODULE_STOP, 8'h00);
      rd(OFF_CTRL_HIGH, 8'h80);
      rd(OFF_TX_DATA, 8'h00);
      rd(3'h7, 8'h00);
      $display("test module stop done");
      kbd_model_i.hold(1'b1, 1'b1);
      cyc(6);
      rd(OFF_CTRL_LOW, 8'h78);
      wr(OFF_CTRL_HIGH, 8'h40);
      cyc(6);
      rd(OFF_CTRL_LOW, 8'h98);
      rd(OFF_IRQ_STATUS, 8'h01);
      chk(irq, 1'b0);
      wr(OFF_IRQ_MASK, 8'h01);
      cyc(3);
      chk(irq, 1'b1);
      kbd_model_i.hold(1'b0, 1'b0);
      cyc(6);
      wr(OFF_CTRL_LOW, 8'h18);
      wr(OFF_IRQ_STATUS, 8'h01);
      cyc(3);
      chk(irq, 1'b0);
      rd(OFF_CTRL_LOW, 8'h78);
      cyc(0);
      kbd_model_i.pulse();
      cyc(6);
      rd(OFF_CTRL_LOW, 8'hf8);
      chk(irq, 1'b1);
      wr(OFF_CTRL_LOW, 8'h18);
      wr(OFF_IRQ_STATUS, 8'h01);
      $display("test io enable and clock fall flag done");
      wr(OFF_CTRL_HIGH, 8'he0);
      b1 = 8'($random(seed));
      cyc(0);
      kbd_model_i.send(b1, ab);
      cyc(6);
      rd(OFF_CTRL_LOW, 8'hf8);
      rd(OFF_RX_BUFFER, b1);
      cyc(0);
      kbd_model_i.send(~b1, ab);
      cyc(6);
      rd(OFF_RX_BUFFER, b1);
      wr(OFF_CTRL_LOW, 8'h18);
      wr(OFF_IRQ_STATUS, 8'h03);
      $display("test receive done");
      txb = 8'($random(seed));
      wr(OFF_TX_DATA, txb);
      wr(OFF_CTRL_HIGH, 8'hf0);
      cyc(0);
      kbd_model_i.recv(frame);
      cyc(6);
      chk(frame, {1'b1, ~^txb, txb, 1'b0});
      rd(OFF_IRQ_STATUS, 8'h02);
      chk(data_w, 1'b1);
      $display("test transmit done");
      wr(OFF_CTRL_LOW, 8'h08);
      cyc(3);
      chk(clk_w, 1'b0);
      kbd_model_i.send(8'($random(seed)), ab);
      cyc(1);
      chk(ab, 1'b1);
      wr(OFF_CTRL_LOW, 8'h18);
      cyc(3);
      chk(clk_w, 1'b1);
      $display("test abort done");
      tally_and_finish();
   end
endmodule
